/* File: common/mac_stats_pkg.sv */
package mac_stats_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Counter bank layout
	localparam int NUM_CNT = 12;
	localparam int IDX_TX_OK = 0;
	localparam int IDX_RX_OK = 1;
	localparam int IDX_CRS = 2;
	localparam int IDX_LATE = 3;
	localparam int IDX_DEFER = 4;
	localparam int IDX_OVR = 5;
	localparam int IDX_LDEF = 6;
	localparam int IDX_ABORT = 7;
	localparam int IDX_TX_BC = 8;
	localparam int IDX_RX_BC = 9;
	localparam int IDX_TX_MC = 10;
	localparam int IDX_RX_MC = 11;

	// Byte offsets in I/O space
	localparam logic [7:0] OFS_TX_OK = 8'h70;
	localparam logic [7:0] OFS_RX_OK = 8'h72;
	localparam logic [7:0] OFS_CRS = 8'h74;
	localparam logic [7:0] OFS_LATE = 8'h75;
	localparam logic [7:0] OFS_DEFER = 8'h78;
	localparam logic [7:0] OFS_OVR = 8'h79;
	localparam logic [7:0] OFS_LDEF = 8'h7A;
	localparam logic [7:0] OFS_ABORT = 8'h7B;
	localparam logic [7:0] OFS_TX_BC = 8'h7C;
	localparam logic [7:0] OFS_RX_BC = 8'h7D;
	localparam logic [7:0] OFS_TX_MC = 8'h7E;
	localparam logic [7:0] OFS_RX_MC = 8'h7F;

	// Limits and thresholds
	localparam logic [15:0] MAX16 = 16'hFFFF;
	localparam logic [15:0] MAX8 = 16'h00FF;
	localparam logic [15:0] MAX4 = 16'h000F;
	localparam logic [15:0] THR16 = 16'hC000;
	localparam logic [15:0] THR8 = 16'h00C0;
	localparam logic [15:0] THR4 = 16'h000C;
	localparam logic [15:0] CNT_RESET = 16'h0000;

	// Host read request and answer
	typedef struct packed {
		logic rd;
		logic [7:0] addr;
	} io_req_s;

	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} io_rsp_s;

	// Event strobes from the MAC transmit and receive logic
	typedef struct packed {
		logic tx_start;
		logic tx_done;
		logic tx_dest_bcast;
		logic tx_dest_group;
		logic tx_first_deferred;
		logic tx_any_collision;
		logic tx_defer_limit;
		logic tx_retry_abort;
		logic tx_late_collision;
		logic tx_past_sfd;
		logic tx_carrier_gone;
		logic rx_done;
		logic rx_dest_bcast;
		logic rx_dest_group;
		logic rx_overrun;
		logic short_frame_flag;
		logic misaligned_frame_flag;
		logic checksum_bad_flag;
		logic too_long_frame_flag;
		logic rx_mac_fault;
		logic rx_trunc_overrun;
		logic rx_addr_match;
		logic rx_full_at_start;
	} mac_events_s;

	// Whole state of the counter bank
	typedef struct packed {
		logic [NUM_CNT-1:0][15:0] cnt;
		logic [15:0] rdata;
		logic rvalid;
		logic thr_evt;
		logic intr;
		logic long_defer_seen;
	} stats_state_s;

endpackage

/* File: core/mac_statistics_counters.sv */
`timescale 1ns/1ps
module mac_statistics_counters (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic counting_enable,
	input wire logic update_stats_intr_enable,
	input wire mac_stats_pkg::io_req_s io_req,
	input wire mac_stats_pkg::mac_events_s events,
	output mac_stats_pkg::io_rsp_s io_rsp,
	output logic counter_threshold_event,
	output logic update_stats_intr
);
	import mac_stats_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Per-counter constants

	function automatic logic [7:0] cnt_offset(input int i);
		logic [7:0] o;
		o = 8'h00;
		if (i == IDX_TX_OK) o = OFS_TX_OK;
		else if (i == IDX_RX_OK) o = OFS_RX_OK;
		else if (i == IDX_CRS) o = OFS_CRS;
		else if (i == IDX_LATE) o = OFS_LATE;
		else if (i == IDX_DEFER) o = OFS_DEFER;
		else if (i == IDX_OVR) o = OFS_OVR;
		else if (i == IDX_LDEF) o = OFS_LDEF;
		else if (i == IDX_ABORT) o = OFS_ABORT;
		else if (i == IDX_TX_BC) o = OFS_TX_BC;
		else if (i == IDX_RX_BC) o = OFS_RX_BC;
		else if (i == IDX_TX_MC) o = OFS_TX_MC;
		else o = OFS_RX_MC;
		return o;
	endfunction

	function automatic logic [15:0] cnt_max(input int i);
		logic [15:0] m;
		if (i == IDX_TX_OK || i == IDX_RX_OK) m = MAX16;
		else if (i == IDX_CRS) m = MAX4;
		else m = MAX8;
		return m;
	endfunction

	function automatic logic [15:0] cnt_thresh(input int i);
		logic [15:0] t;
		if (i == IDX_TX_OK || i == IDX_RX_OK) t = THR16;
		else if (i == IDX_CRS) t = THR4;
		else t = THR8;
		return t;
	endfunction

	// Read decode, shared by the datapath and the checks
	function automatic logic read_hit(input io_req_s r, input int i);
		return r.rd && (r.addr == cnt_offset(i));
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Event classification

	stats_state_s s_r;
	stats_state_s s_nxt;
	logic rx_bad;
	logic rx_good;
	logic ldef_first;
	logic [NUM_CNT-1:0] evt;
	logic [NUM_CNT-1:0] inc;

	// Any error flag disqualifies a received frame
	assign rx_bad = events.rx_overrun | events.short_frame_flag
		| events.misaligned_frame_flag | events.checksum_bad_flag
		| events.too_long_frame_flag | events.rx_mac_fault;
	assign rx_good = events.rx_done & ~rx_bad;

	// A new frame opens the window again, so a late limit strobe still counts
	assign ldef_first = events.tx_defer_limit & (events.tx_start | ~s_r.long_defer_seen);

	// Raw events per counter
	always_comb begin
		evt = '0;
		evt[IDX_TX_OK] = events.tx_done;
		evt[IDX_RX_OK] = rx_good;
		evt[IDX_CRS] = events.tx_carrier_gone & events.tx_past_sfd
			& ~events.tx_any_collision;
		evt[IDX_LATE] = events.tx_late_collision;
		evt[IDX_DEFER] = events.tx_done & events.tx_first_deferred
			& ~events.tx_any_collision;
		evt[IDX_OVR] = events.rx_trunc_overrun & events.rx_addr_match
			& ~events.rx_full_at_start;
		evt[IDX_LDEF] = ldef_first;
		evt[IDX_ABORT] = events.tx_retry_abort;
		evt[IDX_TX_BC] = events.tx_done & events.tx_dest_bcast;
		evt[IDX_RX_BC] = rx_good & events.rx_dest_bcast;
		evt[IDX_TX_MC] = events.tx_done & events.tx_dest_group
			& ~events.tx_dest_bcast;
		evt[IDX_RX_MC] = rx_good & events.rx_dest_group & ~events.rx_dest_bcast;
	end

	// No counter moves on network events while gathering is off; long_defer_seen still follows them
	assign inc = evt & {NUM_CNT{counting_enable}};

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic

	// One pass over the bank; a read clears first, then the event adds on top
	always_comb begin
		logic [15:0] base;
		logic hit_any;
		base = '0;
		hit_any = 1'b0;
		s_nxt = s_r;
		s_nxt.rvalid = 1'b0;
		s_nxt.thr_evt = 1'b0;
		s_nxt.intr = 1'b0;
		if (events.tx_start) begin
			s_nxt.long_defer_seen = 1'b0;
		end
		if (events.tx_defer_limit) begin
			s_nxt.long_defer_seen = 1'b1;
		end
		for (int i = 0; i < NUM_CNT; i++) begin
			base = s_r.cnt[i];
			if (read_hit(io_req, i)) begin
				s_nxt.rdata = s_r.cnt[i];
				hit_any = 1'b1;
				base = CNT_RESET;
			end
			if (inc[i]) begin
				if (i == IDX_CRS && base == MAX4) begin
					s_nxt.cnt[i] = base;
				end else begin
					s_nxt.cnt[i] = (base + 16'h0001) & cnt_max(i);
				end
				// Crossing is judged on the value before the increment
				if (base == cnt_thresh(i)) begin
					s_nxt.thr_evt = 1'b1;
				end
			end else begin
				s_nxt.cnt[i] = base;
			end
		end
		// Unmapped reads still answer, with zero, so the host never hangs
		if (io_req.rd) begin
			s_nxt.rvalid = 1'b1;
			if (!hit_any) begin
				s_nxt.rdata = 16'h0000;
			end
		end
		s_nxt.intr = s_nxt.thr_evt & update_stats_intr_enable;
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs come straight from the state flops
	assign io_rsp.valid = s_r.rvalid;
	assign io_rsp.data = s_r.rdata;
	assign counter_threshold_event = s_r.thr_evt;
	assign update_stats_intr = s_r.intr;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	sequence rd_tx_ok;
		read_hit(io_req, IDX_TX_OK);
	endsequence

	sequence idle_late;
		!read_hit(io_req, IDX_LATE);
	endsequence

	sequence ldef_twice;
		(counting_enable && events.tx_defer_limit && !read_hit(io_req, IDX_LDEF))
		##1 (events.tx_defer_limit && !events.tx_start && !read_hit(io_req, IDX_LDEF));
	endsequence

	// Clearing read and a count in the same cycle
	sequence race_late;
		read_hit(io_req, IDX_LATE) && inc[IDX_LATE];
	endsequence

	// Read port: answer carries the old count, then the counter is empty
	a_read_returns_count: assert property (
		rd_tx_ok |=> io_rsp.valid && io_rsp.data == $past(s_r.cnt[IDX_TX_OK])
	) else $error("read answer does not carry prior count");

	a_read_rx_count: assert property (
		read_hit(io_req, IDX_RX_OK)
		|=> io_rsp.valid && io_rsp.data == $past(s_r.cnt[IDX_RX_OK])
	) else $error("receive count read back wrong");

	a_read_clears_cnt: assert property (
		rd_tx_ok and !inc[IDX_TX_OK] |=> s_r.cnt[IDX_TX_OK] == 16'h0000
	) else $error("read did not clear counter");

	a_read_clears_crs: assert property (
		read_hit(io_req, IDX_CRS) && !inc[IDX_CRS]
		|=> s_r.cnt[IDX_CRS] == 16'h0000
	) else $error("carrier counter not cleared by read");

	// Unmapped offsets answer zero so a host poll never stalls
	a_unmapped_zero: assert property (
		io_req.rd && io_req.addr == 8'h71
		|=> io_rsp.valid && io_rsp.data == 16'h0000
	) else $error("unmapped read did not answer zero");

	a_no_stray_valid: assert property (
		!io_req.rd |=> !io_rsp.valid
	) else $error("answer without a read");

	a_read_race_one: assert property (
		read_hit(io_req, IDX_RX_OK) && inc[IDX_RX_OK] |=> s_r.cnt[IDX_RX_OK] == 16'h0001
	) else $error("event lost during clearing read");

	a_race_late_one: assert property (
		race_late
		|=> s_r.cnt[IDX_LATE] == 16'h0001 && io_rsp.data == $past(s_r.cnt[IDX_LATE])
	) else $error("racing read lost old value or new event");

	a_enable_gates_all: assert property (
		!counting_enable && !io_req.rd |=> s_r.cnt == $past(s_r.cnt)
	) else $error("counter moved while gathering off");

	// Width, wrap and saturation of the counters
	a_wrap_eight_bit: assert property (
		s_r.cnt[IDX_LATE] == MAX8 && inc[IDX_LATE] and idle_late
		|=> s_r.cnt[IDX_LATE] == 16'h0000
	) else $error("eight-bit counter did not wrap");

	a_eight_bit_range: assert property (
		s_r.cnt[IDX_LATE] <= MAX8
	) else $error("eight-bit counter out of range");

	a_wrap_sixteen: assert property (
		s_r.cnt[IDX_TX_OK] == MAX16 && inc[IDX_TX_OK] && !read_hit(io_req, IDX_TX_OK)
		|=> s_r.cnt[IDX_TX_OK] == 16'h0000
	) else $error("sixteen-bit counter did not wrap");

	a_carrier_sticks: assert property (
		s_r.cnt[IDX_CRS] == MAX4 && !read_hit(io_req, IDX_CRS)
		|=> s_r.cnt[IDX_CRS] == MAX4
	) else $error("carrier counter left saturation");

	a_carrier_range: assert property (
		s_r.cnt[IDX_CRS] <= MAX4
	) else $error("carrier counter above four bits");

	// Threshold events and their interrupt
	a_thresh_event: assert property (
		s_r.cnt[IDX_RX_BC] == THR8 && inc[IDX_RX_BC] && !read_hit(io_req, IDX_RX_BC)
		|=> counter_threshold_event
	) else $error("threshold crossing not signalled");

	a_thresh_rx16: assert property (
		s_r.cnt[IDX_RX_OK] == THR16 && inc[IDX_RX_OK] && !read_hit(io_req, IDX_RX_OK)
		|=> counter_threshold_event && s_r.cnt[IDX_RX_OK] == 16'hC001
	) else $error("receive threshold crossing wrong");

	a_thresh_crs: assert property (
		s_r.cnt[IDX_CRS] == THR4 && inc[IDX_CRS] && !read_hit(io_req, IDX_CRS)
		|=> counter_threshold_event
	) else $error("carrier threshold crossing not signalled");

	a_no_idle_event: assert property (
		inc == '0 |=> !counter_threshold_event
	) else $error("threshold event without a count");

	a_intr_gated: assert property (
		counter_threshold_event |-> update_stats_intr == $past(update_stats_intr_enable)
	) else $error("interrupt not gated by enable");

	a_intr_needs_event: assert property (
		update_stats_intr |-> counter_threshold_event
	) else $error("interrupt without threshold event");

	// Receive classification
	a_rx_ok_counts: assert property (
		rx_good && counting_enable && !read_hit(io_req, IDX_RX_OK)
		|=> s_r.cnt[IDX_RX_OK] == $past(s_r.cnt[IDX_RX_OK]) + 16'h0001
	) else $error("good frame not counted");

	a_bad_rx_blocked: assert property (
		events.rx_done && rx_bad && !read_hit(io_req, IDX_RX_OK)
		|=> s_r.cnt[IDX_RX_OK] == $past(s_r.cnt[IDX_RX_OK])
	) else $error("error frame counted as good");

	a_bad_rx_bcast: assert property (
		events.rx_done && rx_bad && !read_hit(io_req, IDX_RX_BC)
		|=> s_r.cnt[IDX_RX_BC] == $past(s_r.cnt[IDX_RX_BC])
	) else $error("error frame counted as broadcast");

	a_rx_bc_counts: assert property (
		rx_good && events.rx_dest_bcast && counting_enable && !read_hit(io_req, IDX_RX_BC)
		|=> s_r.cnt[IDX_RX_BC] == (($past(s_r.cnt[IDX_RX_BC]) + 16'h0001) & MAX8)
	) else $error("broadcast receive not counted");

	a_rx_mc_no_bc: assert property (
		events.rx_dest_bcast && !read_hit(io_req, IDX_RX_MC)
		|=> s_r.cnt[IDX_RX_MC] == $past(s_r.cnt[IDX_RX_MC])
	) else $error("broadcast receive counted as group");

	a_ovr_full_start: assert property (
		events.rx_full_at_start && !read_hit(io_req, IDX_OVR)
		|=> s_r.cnt[IDX_OVR] == $past(s_r.cnt[IDX_OVR])
	) else $error("frame dropped at start counted as overrun");

	// Transmit classification
	a_tx_ok_counts: assert property (
		events.tx_done && counting_enable && !read_hit(io_req, IDX_TX_OK)
		|=> s_r.cnt[IDX_TX_OK] == $past(s_r.cnt[IDX_TX_OK]) + 16'h0001
	) else $error("sent frame not counted");

	a_tx_bc_only: assert property (
		events.tx_done && !events.tx_dest_bcast && !read_hit(io_req, IDX_TX_BC)
		|=> s_r.cnt[IDX_TX_BC] == $past(s_r.cnt[IDX_TX_BC])
	) else $error("non-broadcast send counted as broadcast");

	a_tx_mc_no_bc: assert property (
		events.tx_dest_bcast && !read_hit(io_req, IDX_TX_MC)
		|=> s_r.cnt[IDX_TX_MC] == $past(s_r.cnt[IDX_TX_MC])
	) else $error("broadcast send counted as group");

	a_crs_needs_sfd: assert property (
		!events.tx_past_sfd && !read_hit(io_req, IDX_CRS)
		|=> s_r.cnt[IDX_CRS] == $past(s_r.cnt[IDX_CRS])
	) else $error("carrier loss counted before delimiter");

	a_crs_no_coll: assert property (
		events.tx_any_collision && !read_hit(io_req, IDX_CRS)
		|=> s_r.cnt[IDX_CRS] == $past(s_r.cnt[IDX_CRS])
	) else $error("carrier loss counted during collision");

	a_abort_counts: assert property (
		events.tx_retry_abort && counting_enable && !read_hit(io_req, IDX_ABORT)
		|=> s_r.cnt[IDX_ABORT] == (($past(s_r.cnt[IDX_ABORT]) + 16'h0001) & MAX8)
	) else $error("retry abort not counted");

	a_defer_counts: assert property (
		evt[IDX_DEFER] && counting_enable && !read_hit(io_req, IDX_DEFER)
		|=> s_r.cnt[IDX_DEFER] == (($past(s_r.cnt[IDX_DEFER]) + 16'h0001) & MAX8)
	) else $error("deferred send not counted");

	a_defer_no_coll: assert property (
		events.tx_any_collision && !read_hit(io_req, IDX_DEFER)
		|=> s_r.cnt[IDX_DEFER] == $past(s_r.cnt[IDX_DEFER])
	) else $error("collided frame counted as deferred");

	a_long_defer_once: assert property (
		ldef_twice |=> s_r.cnt[IDX_LDEF] == $past(s_r.cnt[IDX_LDEF])
	) else $error("excessive deferral counted twice");

	a_late_counts: assert property (
		events.tx_late_collision && counting_enable && !read_hit(io_req, IDX_LATE)
		|=> s_r.cnt[IDX_LATE] == (($past(s_r.cnt[IDX_LATE]) + 16'h0001) & MAX8)
	) else $error("late collision not counted");

endmodule // mac_statistics_counters

/* File: test/mac_event_model.sv */
`timescale 1ns/1ps
module mac_event_model (
	input wire logic ref_clk,
	input wire logic fire,
	input wire logic [4:0] kind,
	output mac_stats_pkg::mac_events_s events
);
	import mac_stats_pkg::*;
	mac_events_s ev;

	////////////////////////////////////////
	// One frame kind maps to its strobe set
	always_comb begin
		ev = '0;
		ev.tx_done = kind < 5'h05;
		ev.tx_dest_bcast = kind == 5'h01;
		ev.tx_dest_group = kind inside {5'h01, 5'h02};
		ev.tx_first_deferred = kind inside {5'h03, 5'h04};
		ev.tx_any_collision = kind == 5'h04;
		ev.tx_past_sfd = kind == 5'h05;
		ev.tx_carrier_gone = kind inside {5'h05, 5'h06};
		ev.tx_late_collision = kind == 5'h07;
		ev.tx_retry_abort = kind == 5'h08;
		ev.rx_done = kind inside {[5'h09:5'h11]};
		ev.rx_dest_bcast = kind inside {5'h0A, [5'h0C:5'h11]};
		ev.rx_dest_group = kind inside {[5'h0A:5'h11]};
		ev.checksum_bad_flag = kind == 5'h0C;
		ev.short_frame_flag = kind == 5'h0D;
		ev.misaligned_frame_flag = kind == 5'h0E;
		ev.too_long_frame_flag = kind == 5'h0F;
		ev.rx_mac_fault = kind == 5'h10;
		ev.rx_overrun = kind == 5'h11;
		ev.rx_trunc_overrun = kind inside {5'h12, 5'h13};
		ev.rx_addr_match = kind inside {5'h12, 5'h13};
		ev.rx_full_at_start = kind == 5'h13;
		ev.tx_start = kind == 5'h14;
		ev.tx_defer_limit = kind inside {5'h14, 5'h15};
	end

	// Strobes stand one cycle late for each cycle that fire is high, so idle is all zero
	always_ff @(posedge ref_clk) begin
		events <= fire ? ev : '0;
	end
endmodule // mac_event_model

/* File: test/test_mac_statistics_counters.sv */
`timescale 1ns/1ps
module test_mac_statistics_counters;
	import mac_stats_pkg::*;
	typedef struct packed {
		logic en;
		logic [4:0] kind;
		logic [7:0] addr;
		logic [15:0] exp;
	} row_s;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic counting_enable = 1'b1;
	logic update_stats_intr_enable = 1'b1;
	logic fire = 1'b0;
	logic [4:0] kind = 5'h00;
	io_req_s io_req = '0;
	io_rsp_s io_rsp;
	mac_events_s events;
	logic counter_threshold_event;
	logic update_stats_intr;
	logic [15:0] rdat;
	int failures = 0;
	int checks = 0;
	int evt_n = 0;
	int intr_n = 0;
	// One event kind, then one read of one counter
	row_s rows [26] = '{
		'{1'b1, 5'h00, 8'h70, 16'h0001},
		'{1'b1, 5'h01, 8'h7C, 16'h0001},
		'{1'b1, 5'h02, 8'h7C, 16'h0000},
		'{1'b1, 5'h02, 8'h7E, 16'h0001},
		'{1'b1, 5'h01, 8'h7E, 16'h0000},
		'{1'b1, 5'h03, 8'h78, 16'h0001},
		'{1'b1, 5'h04, 8'h78, 16'h0000},
		'{1'b1, 5'h05, 8'h74, 16'h0001},
		'{1'b1, 5'h06, 8'h74, 16'h0000},
		'{1'b1, 5'h07, 8'h75, 16'h0001},
		'{1'b1, 5'h08, 8'h7B, 16'h0001},
		'{1'b1, 5'h09, 8'h72, 16'h0001},
		'{1'b1, 5'h0A, 8'h7D, 16'h0001},
		'{1'b1, 5'h0B, 8'h7F, 16'h0001},
		'{1'b1, 5'h0A, 8'h7F, 16'h0000},
		'{1'b1, 5'h0C, 8'h72, 16'h0000},
		'{1'b1, 5'h0D, 8'h72, 16'h0000},
		'{1'b1, 5'h0E, 8'h72, 16'h0000},
		'{1'b1, 5'h0F, 8'h72, 16'h0000},
		'{1'b1, 5'h10, 8'h72, 16'h0000},
		'{1'b1, 5'h11, 8'h7D, 16'h0000},
		'{1'b1, 5'h0C, 8'h7F, 16'h0000},
		'{1'b1, 5'h12, 8'h79, 16'h0001},
		'{1'b1, 5'h13, 8'h79, 16'h0000},
		'{1'b0, 5'h09, 8'h72, 16'h0000},
		'{1'b1, 5'h00, 8'h71, 16'h0000}
	};

	////////////////////////////////////////
	mac_statistics_counters i_dut (
		.ref_clk(ref_clk),
		.rst(rst),
		.counting_enable(counting_enable),
		.update_stats_intr_enable(update_stats_intr_enable),
		.io_req(io_req),
		.events(events),
		.io_rsp(io_rsp),
		.counter_threshold_event(counter_threshold_event),
		.update_stats_intr(update_stats_intr)
	);
	mac_event_model i_mac (
		.ref_clk(ref_clk),
		.fire(fire),
		.kind(kind),
		.events(events)
	);

	////////////////////////////////////////
	// Clock and pulse counting
	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (counter_threshold_event === 1'b1) evt_n++;
		if (update_stats_intr === 1'b1) intr_n++;
	end

	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Answer stands for the one cycle after the taking edge
	task rd(input logic [7:0] a);
		io_req.rd <= 1'b1;
		io_req.addr <= a;
		@(posedge ref_clk);
		io_req.rd <= 1'b0;
		// Look mid-cycle, while the answer stands settled
		@(negedge ref_clk);
		chk("io_rsp.valid", 16'h0001, {15'h0000, io_rsp.valid});
		rdat = io_rsp.data;
		@(posedge ref_clk);
	endtask
	task fire_n(input logic [4:0] k, input int n);
		kind <= k;
		fire <= 1'b1;
		repeat (n) @(posedge ref_clk);
		fire <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask
	// Reads clear, so sweeping the map zeroes every counter
	task clear_all;
		for (int a = 'h70; a < 'h80; a++) rd(a[7:0]);
		evt_n = 0;
		intr_n = 0;
	endtask
	task end_sim;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	////////////////////////////////////////
	initial begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rd(OFS_TX_OK);
		chk("tx_good_frame_count", 16'h0000, rdat);
		foreach (rows[i]) begin
			clear_all();
			counting_enable <= rows[i].en;
			fire_n(rows[i].kind, 1);
			rd(rows[i].addr);
			chk($sformatf("row %0d", i), rows[i].exp, rdat);
			counting_enable <= 1'b1;
		end
		clear_all();
		fire_n(5'h00, 3);
		rd(OFS_TX_OK);
		chk("tx_good_frame_count", 16'h0003, rdat);
		rd(OFS_TX_OK);
		chk("tx_good_frame_count", 16'h0000, rdat);
		fire_n(5'h14, 1);
		fire_n(5'h15, 2);
		rd(OFS_LDEF);
		chk("long_defer_count", 16'h0001, rdat);
		// Event lands on the very edge that takes the read
		fire_n(5'h07, 2);
		kind <= 5'h07;
		fire <= 1'b1;
		@(posedge ref_clk);
		fire <= 1'b0;
		rd(OFS_LATE);
		chk("late_collision_count", 16'h0002, rdat);
		repeat (2) @(posedge ref_clk);
		rd(OFS_LATE);
		chk("late_collision_count", 16'h0001, rdat);
		clear_all();
		fire_n(5'h07, 'hC1);
		chk("threshold events", 16'h0001, 16'(evt_n));
		chk("interrupts", 16'h0001, 16'(intr_n));
		update_stats_intr_enable <= 1'b0;
		fire_n(5'h07, 'h3F);
		rd(OFS_LATE);
		chk("late_collision_count", 16'h0000, rdat);
		clear_all();
		fire_n(5'h07, 'hC1);
		chk("threshold events", 16'h0001, 16'(evt_n));
		chk("interrupts", 16'h0000, 16'(intr_n));
		clear_all();
		fire_n(5'h05, 20);
		rd(OFS_CRS);
		chk("carrier_loss_count", 16'h000F, rdat);
		chk("threshold events", 16'h0001, 16'(evt_n));
		clear_all();
		fire_n(5'h09, 'hC001);
		rd(OFS_RX_OK);
		chk("rx_good_frame_count", 16'hC001, rdat);
		chk("threshold events", 16'h0001, 16'(evt_n));
		// Reset in mid-run drops counts already gathered
		fire_n(5'h00, 2);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rd(OFS_TX_OK);
		chk("tx_good_frame_count", 16'h0000, rdat);
		end_sim();
	end

	// Whole run needs about 51000 cycles
	initial begin
		repeat (80000) @(posedge ref_clk);
		failures++;
		end_sim();
	end
endmodule // test_mac_statistics_counters
